/* hw/flash_seq_map.svh */
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS 40
`define SETTLE_NS 500
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define EXIT_HOLD_NS 100
`define NOP_COUNT 3'h4
// ----------------------------------------
// flash control register fields
// ----------------------------------------
`define BIT_BUSY 15
`define BIT_ERR 13
`define WRITE_ENABLE_BIT_MASK 16'h4000
`define CLR_OFS 32'h0000_0004
`define WORD_STEP 32'h0000_0004
// ----------------------------------------
// processor op codes
// ----------------------------------------
`define OP_LUI_S3 32'h3c13_ff20
`define OP_LUI_T0 16'h3c08
`define OP_ORI_T0 16'h3508
`define OP_ORI_T1 16'h3409
`define OP_LW_T1 32'h8d09_0000
`define OP_SW_FAST 32'hae69_0000
`define OP_SW_T0 32'had09_0000
`define OP_NOP 32'h0000_0000
// ----------------------------------------
// test port scan shapes, bit 0 first
// ----------------------------------------
`define MODE_EXIT 5'h1f
`define IR_TMS 48'h0000_0000_0303
`define DR_TMS 48'h000c_0000_0001
`define IR_LEN 6'h0b
`define DR_LEN 6'h25
`define MODE_LEN 6'h05
`define PULSE_LEN 6'h01
`endif

/* hw/flash_seq_pkg.sv */
`default_nettype none
package flash_seq_pkg;
  typedef enum logic [2:0] {op_power_on, op_finish, op_verify_pe, op_verify_direct, op_exit} op_t;
  typedef struct packed {
    op_t op;
    logic [31:0] addr;
    logic [15:0] len;
    logic [31:0] cfg_addr;
    logic [15:0] cfg_len;
    logic [31:0] checksum;
  } cmd_t;
  typedef struct packed {
    op_t op;
    logic ok;
    logic [31:0] fail_addr;
    logic [31:0] got;
  } res_t;
  typedef enum logic [1:0] {sh_ir, sh_dr, sh_mode, sh_pulse} sh_kind_t;
  typedef struct packed {
    logic valid;
    sh_kind_t kind;
    logic [31:0] data;
  } sh_req_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic tck;
    logic tms;
    logic tdi;
    logic sync1;
    logic sync2;
    logic [7:0] div;
    logic [5:0] len;
    logic [5:0] idx;
    logic [47:0] tms_v;
    logic [47:0] tdi_v;
    logic [33:0] cap;
    logic [31:0] rdata;
  } sh_state_t;
  typedef enum logic [3:0] {
    st_idle, st_xfer, st_rd, st_fw, st_busy, st_nop, st_clr, st_err,
    st_pe, st_dir, st_cmp, st_hold, st_off
  } main_st_t;
  typedef struct packed {
    main_st_t st;
    main_st_t ret;
    main_st_t rd_ret;
    logic [1:0] ph;
    sh_kind_t x_kind;
    logic [4:0] x_ir;
    logic [31:0] x_word;
    logic [2:0] step;
    logic [31:0] rdat;
    cmd_t cmd;
    logic [31:0] addr;
    logic [15:0] left;
    logic cfg_done;
    logic [2:0] nops;
    logic [15:0] timer;
    logic [15:0] since;
    logic master_clear_pin_n;
    logic power;
    logic cmd_ready;
    logic res_valid;
    res_t res;
    sh_req_t req;
  } main_t;
endpackage : flash_seq_pkg
`default_nettype wire

/* hw/word_fifo.sv */
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_ready;
    logic out_valid;
  } fifo_state_t;
  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;
  assign push = in_valid && s_r.in_ready;
  assign pop = out_ready && s_r.out_valid;
  assign in_ready = s_r.in_ready;
  assign out_valid = s_r.out_valid;
  assign out_data = mem[s_r.rp];
  always_comb
  begin
    s_nxt = s_r;
    if (push)
      s_nxt.wp = s_r.wp + AW'(1);
    if (pop)
      s_nxt.rp = s_r.rp + AW'(1);
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_nxt.in_ready = s_nxt.cnt != (AW+1)'(DEPTH);
    s_nxt.out_valid = s_nxt.cnt != '0;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.in_ready <= 1'b1;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
      if (push)
        mem[s_r.wp] <= in_data;
    end
  end
endmodule : word_fifo
`default_nettype wire

/* hw/tap_shifter.sv */
`default_nettype none
`include "flash_seq_map.svh"
module tap_shifter import flash_seq_pkg::*; #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire sh_req_t req,
  output logic done,
  output logic [31:0] rdata,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
  sh_state_t s_r;
  sh_state_t s_nxt;
  assign done = s_r.done;
  assign rdata = s_r.rdata;
  assign tck = s_r.tck;
  assign tms = s_r.tms;
  assign tdi = s_r.tdi;
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.sync1 = tdo;
    s_nxt.sync2 = s_r.sync1;
    if (!s_r.busy)
    begin
      if (req.valid)
      begin
        s_nxt.busy = 1'b1;
        s_nxt.idx = '0;
        s_nxt.div = '0;
        s_nxt.tdi_v = '0;
        s_nxt.tms_v = '0;
        case (req.kind)
          sh_ir:
          begin
            s_nxt.tms_v = `IR_TMS;
            s_nxt.tdi_v = {39'h0, req.data[4:0], 4'h0};
            s_nxt.len = `IR_LEN;
          end
          sh_dr:
          begin
            s_nxt.tms_v = `DR_TMS;
            s_nxt.tdi_v = {13'h0, req.data, 3'h0};
            s_nxt.len = `DR_LEN;
          end
          sh_mode:
          begin
            s_nxt.tms_v = {43'h0, `MODE_EXIT};
            s_nxt.len = `MODE_LEN;
          end
          default:
            s_nxt.len = `PULSE_LEN;
        endcase
        s_nxt.tms = s_nxt.tms_v[0];
        s_nxt.tdi = s_nxt.tdi_v[0];
      end
    end
    else if (s_r.div != HALF_M1)
      s_nxt.div = s_r.div + 8'h1;
    else
    begin
      s_nxt.div = '0;
      if (!s_r.tck)
      begin
        // sample on the rising edge
        s_nxt.tck = 1'b1;
        s_nxt.cap = {s_r.sync2, s_r.cap[33:1]};
      end
      else
      begin
        s_nxt.tck = 1'b0;
        if (s_r.idx == s_r.len - 6'h1)
        begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.rdata = s_r.cap[31:0];
        end
        else
        begin
          s_nxt.idx = s_r.idx + 6'h1;
          s_nxt.tms_v = s_r.tms_v >> 1;
          s_nxt.tdi_v = s_r.tdi_v >> 1;
          s_nxt.tms = s_r.tms_v[1];
          s_nxt.tdi = s_r.tdi_v[1];
        end
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end
endmodule : tap_shifter
`default_nettype wire

/* hw/flash_verify_exit_host.sv */
// Behaviour
// - wait at least 500 ns after busy reads zero before any control write
// - feed four no-operation instructions as the settle delay
// - clear write enable bit 14 by a store to the clear alias
// - read the write error flag after a write and report failure
// - executive verify: command, start, length, then zero word returns checksum
// - direct verify: processor loads word, stores to fast data, host reads it
// - repeat direct read for every location and compare with buffered copy
// - verify configuration words in the same pass as code memory
// - exit: all-ones mode sequence, assert master clear, remove power
// - two-wire exit adds one programming clock pulse before power removal
// - hold interval between last clock or data activity and master clear
`default_nettype none
`include "flash_seq_map.svh"
module flash_verify_exit_host import flash_seq_pkg::*; #(
  parameter int HALF = 4,
  parameter int FIFO_DEPTH = 16,
  parameter int EXIT_HOLD_NS = `EXIT_HOLD_NS,
  parameter logic [31:0] CTRL_ADDR = 32'h0000_1000,
  parameter logic [31:0] CHECKSUM_CMD = 32'h0007_0000,
  parameter logic [4:0] IR_INSTR = 5'h09,
  parameter logic [4:0] IR_FAST = 5'h0e
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  output logic cmd_ready,
  output logic res_valid,
  output var res_t res,
  input wire logic exp_valid,
  input wire logic [31:0] exp_data,
  output logic exp_ready,
  input wire logic two_wire,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  output logic master_clear_pin_n,
  output logic target_power
);
  localparam logic [15:0] SETTLE = 16'(`SETTLE_CYC);
  localparam logic [15:0] HOLD = 16'((EXIT_HOLD_NS + `CLK_NS - 1) / `CLK_NS);
  localparam logic [31:0] CLR_ADDR = CTRL_ADDR + `CLR_OFS;
  main_t s_r;
  main_t s_nxt;
  logic sh_done;
  logic [31:0] sh_rdata;
  logic exp_out_valid;
  logic [31:0] exp_out_data;
  logic exp_pop;
  assign cmd_ready = s_r.cmd_ready;
  assign res_valid = s_r.res_valid;
  assign res = s_r.res;
  assign master_clear_pin_n = s_r.master_clear_pin_n;
  assign target_power = s_r.power;
  assign exp_pop = s_r.st == st_cmp;
  // ----------------------------------------
  // expected data buffer and scan engine
  // ----------------------------------------
  word_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .in_valid(exp_valid),
    .in_data(exp_data),
    .in_ready(exp_ready),
    .out_valid(exp_out_valid),
    .out_data(exp_out_data),
    .out_ready(exp_pop)
  );
  tap_shifter #(.HALF(HALF)) u_shift (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .req(s_r.req),
    .done(sh_done),
    .rdata(sh_rdata),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo)
  );
  // ----------------------------------------
  // sequencing helpers
  // ----------------------------------------
  function automatic main_t go_xfer(main_t m, logic [4:0] ir, logic [31:0] w, main_st_t ret);
    main_t r;
    r = m;
    r.st = st_xfer;
    r.ph = 2'h0;
    r.x_ir = ir;
    r.x_word = w;
    r.x_kind = sh_dr;
    r.ret = ret;
    return r;
  endfunction : go_xfer
  function automatic main_t go_raw(main_t m, sh_kind_t k, logic [31:0] w, main_st_t ret);
    main_t r;
    r = m;
    r.st = st_xfer;
    r.ph = 2'h2;
    r.x_kind = k;
    r.x_word = w;
    r.ret = ret;
    return r;
  endfunction : go_raw
  function automatic main_t go_rd(main_t m, main_st_t ret);
    main_t r;
    r = m;
    r.st = st_rd;
    r.step = 3'h0;
    r.rd_ret = ret;
    return r;
  endfunction : go_rd
  function automatic main_t finish(main_t m, logic ok);
    main_t r;
    r = m;
    r.res_valid = 1'b1;
    r.res.op = m.cmd.op;
    r.res.ok = ok;
    r.res.fail_addr = m.addr;
    r.res.got = m.rdat;
    r.st = st_idle;
    r.cmd_ready = 1'b1;
    return r;
  endfunction : finish
  // load word at addr into t1, store it to the fast data slot
  function automatic logic [31:0] rd_word(logic [2:0] step, logic [31:0] addr);
    case (step)
      3'h0: return {`OP_LUI_T0, addr[31:16]};
      3'h1: return {`OP_ORI_T0, addr[15:0]};
      3'h2: return `OP_LW_T1;
      3'h3: return `OP_SW_FAST;
      default: return 32'h0000_0000;
    endcase
  endfunction : rd_word
  function automatic logic [31:0] clr_word(logic [2:0] step);
    case (step)
      3'h0: return {`OP_LUI_T0, CLR_ADDR[31:16]};
      3'h1: return {`OP_ORI_T0, CLR_ADDR[15:0]};
      3'h2: return {`OP_ORI_T1, `WRITE_ENABLE_BIT_MASK};
      default: return `OP_SW_T0;
    endcase
  endfunction : clr_word
  function automatic logic [31:0] pe_word(logic [2:0] step, cmd_t c);
    case (step)
      3'h0: return CHECKSUM_CMD;
      3'h1: return c.addr;
      3'h2: return {16'h0, c.len};
      default: return 32'h0000_0000;
    endcase
  endfunction : pe_word
  // ----------------------------------------
  // main sequencer
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.req.valid = 1'b0;
    s_nxt.res_valid = 1'b0;
    if (s_r.timer != 16'h0)
      s_nxt.timer = s_r.timer - 16'h1;
    if (s_r.since != 16'hffff)
      s_nxt.since = s_r.since + 16'h1;
    case (s_r.st)
      st_idle:
        if (cmd_valid && s_r.cmd_ready)
        begin
          s_nxt.cmd = cmd;
          s_nxt.cmd_ready = 1'b0;
          s_nxt.step = 3'h0;
          s_nxt.cfg_done = 1'b0;
          s_nxt.addr = cmd.addr;
          s_nxt.left = cmd.len;
          case (cmd.op)
            op_power_on:
            begin
              s_nxt.power = 1'b1;
              s_nxt.master_clear_pin_n = 1'b1;
              s_nxt = finish(s_nxt, 1'b1);
            end
            op_finish:
            begin
              s_nxt.addr = CTRL_ADDR;
              s_nxt = go_xfer(s_nxt, IR_INSTR, `OP_LUI_S3, st_fw);
            end
            op_verify_pe:
              s_nxt.st = st_pe;
            op_verify_direct:
              s_nxt.st = st_dir;
            default:
              s_nxt = go_raw(s_nxt, sh_mode, {27'h0, `MODE_EXIT}, st_hold);
          endcase
        end
      st_xfer:
        case (s_r.ph)
          2'h0:
          begin
            s_nxt.req = '{valid: 1'b1, kind: sh_ir, data: {27'h0, s_r.x_ir}};
            s_nxt.ph = 2'h1;
          end
          2'h1:
            if (sh_done)
              s_nxt.ph = 2'h2;
          2'h2:
          begin
            s_nxt.req = '{valid: 1'b1, kind: s_r.x_kind, data: s_r.x_word};
            s_nxt.ph = 2'h3;
          end
          default:
            if (sh_done)
            begin
              s_nxt.rdat = sh_rdata;
              s_nxt.st = s_r.ret;
            end
        endcase
      st_rd:
        if (s_r.step == 3'h5)
          s_nxt.st = s_r.rd_ret;
        else
        begin
          // last step reads the fast data register back
          s_nxt = go_xfer(s_nxt, (s_r.step == 3'h4) ? IR_FAST : IR_INSTR, rd_word(s_r.step, s_r.addr), st_rd);
          s_nxt.step = s_r.step + 3'h1;
        end
      st_fw:
        s_nxt = go_rd(s_nxt, st_busy);
      st_busy:
        if (s_r.rdat[`BIT_BUSY])
          s_nxt = go_rd(s_nxt, st_busy);
        else
        begin
          s_nxt.timer = SETTLE;
          s_nxt.since = 16'h0;
          s_nxt.nops = 3'h0;
          s_nxt.st = st_nop;
        end
      st_nop:
        if (s_r.nops != `NOP_COUNT)
        begin
          s_nxt = go_xfer(s_nxt, IR_INSTR, `OP_NOP, st_nop);
          s_nxt.nops = s_r.nops + 3'h1;
        end
        else if (s_r.timer == 16'h0)
        begin
          s_nxt.st = st_clr;
          s_nxt.step = 3'h0;
        end
      st_clr:
        if (s_r.step == 3'h4)
          s_nxt = go_rd(s_nxt, st_err);
        else
        begin
          s_nxt = go_xfer(s_nxt, IR_INSTR, clr_word(s_r.step), st_clr);
          s_nxt.step = s_r.step + 3'h1;
        end
      st_err:
        s_nxt = finish(s_nxt, !s_r.rdat[`BIT_ERR]);
      st_pe:
        if (s_r.step == 3'h4)
          s_nxt = finish(s_nxt, s_r.rdat == s_r.cmd.checksum);
        else
        begin
          s_nxt = go_xfer(s_nxt, IR_FAST, pe_word(s_r.step, s_r.cmd), st_pe);
          s_nxt.step = s_r.step + 3'h1;
        end
      st_dir:
        if (s_r.step == 3'h0)
        begin
          s_nxt = go_xfer(s_nxt, IR_INSTR, `OP_LUI_S3, st_dir);
          s_nxt.step = 3'h1;
        end
        else if (s_r.left == 16'h0)
        begin
          if (!s_r.cfg_done && s_r.cmd.cfg_len != 16'h0)
          begin
            // configuration words follow in the same pass
            s_nxt.addr = s_r.cmd.cfg_addr;
            s_nxt.left = s_r.cmd.cfg_len;
            s_nxt.cfg_done = 1'b1;
          end
          else
            s_nxt = finish(s_nxt, 1'b1);
        end
        else
          s_nxt = go_rd(s_nxt, st_cmp);
      st_cmp:
        if (exp_out_valid)
        begin
          if (exp_out_data != s_r.rdat)
            s_nxt = finish(s_nxt, 1'b0);
          else
          begin
            s_nxt.addr = s_r.addr + `WORD_STEP;
            s_nxt.left = s_r.left - 16'h1;
            s_nxt.step = 3'h1;
            s_nxt.st = st_dir;
          end
        end
      st_hold:
        if (s_r.step == 3'h0)
        begin
          s_nxt.timer = HOLD;
          s_nxt.since = 16'h0;
          s_nxt.step = 3'h1;
        end
        else if (s_r.timer == 16'h0)
        begin
          s_nxt.master_clear_pin_n = 1'b0;
          if (two_wire)
            s_nxt = go_raw(s_nxt, sh_pulse, 32'h0000_0000, st_off);
          else
            s_nxt.st = st_off;
        end
      st_off:
      begin
        s_nxt.power = 1'b0;
        s_nxt = finish(s_nxt, 1'b1);
      end
      default:
        s_nxt.st = st_idle;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.cmd_ready <= 1'b1;
    end
    else if (ce)
      s_r <= s_nxt;
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_settle;
    $rose(s_r.st == st_clr) |-> s_r.since >= SETTLE;
  endproperty
  a_settle: assert property (p_settle) else $error("control write before settle time");
  property p_nops;
    $rose(s_r.st == st_clr) |-> s_r.nops == `NOP_COUNT;
  endproperty
  a_nops: assert property (p_nops) else $error("wrong number of settle no-ops");
  property p_write_enable_bit;
    (s_r.st == st_xfer && s_r.ret == st_clr && s_r.step == 3'h3 && s_r.ph == 2'h2)
      |=> s_r.req.valid && s_r.req.data == {`OP_ORI_T1, `WRITE_ENABLE_BIT_MASK};
  endproperty
  a_write_enable_bit: assert property (p_write_enable_bit) else $error("write enable clear mask wrong");
  property p_err;
    s_r.st == st_err |=> s_r.res_valid && s_r.res.ok == !$past(s_r.rdat[`BIT_ERR]);
  endproperty
  a_err: assert property (p_err) else $error("write error flag not reported");
  property p_crc;
    (s_r.st == st_pe && s_r.step == 3'h4) |=> s_r.res_valid && s_r.res.ok == (s_r.rdat == s_r.cmd.checksum);
  endproperty
  a_crc: assert property (p_crc) else $error("checksum compare wrong");
  property p_cmp;
    (s_r.st == st_cmp && exp_out_valid && exp_out_data != s_r.rdat) |=> s_r.res_valid && !s_r.res.ok;
  endproperty
  a_cmp: assert property (p_cmp) else $error("mismatch not reported");
  property p_cfg;
    (s_r.res_valid && s_r.res.op == op_verify_direct && s_r.res.ok && s_r.cmd.cfg_len != 16'h0)
      |-> s_r.cfg_done && s_r.res.fail_addr == s_r.cmd.cfg_addr + 32'(s_r.cmd.cfg_len) * `WORD_STEP;
  endproperty
  a_cfg: assert property (p_cfg) else $error("configuration words skipped");
  property p_mode;
    (s_r.req.valid && s_r.req.kind == sh_mode) |-> s_r.req.data[4:0] == `MODE_EXIT && s_r.master_clear_pin_n;
  endproperty
  a_mode: assert property (p_mode) else $error("exit mode sequence wrong");
  property p_pulse;
    ($fell(s_r.master_clear_pin_n) && two_wire) |=> s_r.req.valid && s_r.req.kind == sh_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("two-wire exit pulse missing");
  property p_hold;
    $fell(s_r.master_clear_pin_n) |-> s_r.since == HOLD + 16'h1;
  endproperty
  a_hold: assert property (p_hold) else $error("exit hold interval wrong");
endmodule : flash_verify_exit_host
`default_nettype wire

/* verif/target_device.sv */
`default_nettype none
`include "flash_seq_map.svh"
module target_device #(
  parameter logic [31:0] CTRL_ADDR = 32'h0000_1000,
  parameter logic [31:0] CHECKSUM_CMD = 32'h0007_0000,
  parameter logic [4:0] IR_INSTR = 5'h09,
  parameter logic [4:0] IR_FAST = 5'h0e
) (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  input wire logic master_clear_pin_n,
  input wire logic err_inject,
  input wire logic protect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] st = 3'h0;
  logic is_ir = 1'b0;
  logic locked = 1'b0;
  logic was_up = 1'b0;
  logic zero_pend = 1'b0;
  logic [4:0] ir = 5'h0;
  logic [31:0] sr = '0, s3 = '0, t0 = '0, t1 = '0, fast = '0, pe_addr = '0, pe_len = '0, ctrl = '0;
  int busy_left, nops, pe, viol, ones, pulses;
  time t_zero, t_act;
  initial tdo = 1'b0;
  // ----
  // test port state walk
  // ----
  function automatic logic [2:0] next_st(input logic [2:0] s, input logic m);
    case (s)
      3'h0: return m ? 3'h1 : 3'h0;
      3'h1: return m ? 3'h2 : 3'h3;
      3'h2: return m ? 3'h0 : 3'h3;
      3'h3, 3'h4: return m ? 3'h5 : 3'h4;
      3'h5: return m ? 3'h6 : 3'h4;
      default: return m ? 3'h1 : 3'h0;
    endcase
  endfunction : next_st
  task automatic load_t1;
    if (locked)
      t1 = 32'h0;
    else if (t0 != CTRL_ADDR)
      t1 = 32'hc0de_0000 + {26'h0, t0[7:2]};
    else
    begin
      busy_left = (busy_left > 0) ? busy_left - 1 : 0;
      if (busy_left == 0 && ctrl[`BIT_BUSY])
      begin
        ctrl[`BIT_BUSY] = 1'b0;
        ctrl[`BIT_ERR] = err_inject;
        zero_pend = 1'b1;
      end
      t1 = ctrl;
    end
  endtask : load_t1
  task automatic exec(input logic [31:0] op);
    case (op[31:16])
      16'h3c13:
      begin
        s3 = {op[15:0], 16'h0};
        ctrl = 32'h0000_c000;
        busy_left = 3;
      end
      16'h3c08: t0 = {op[15:0], 16'h0};
      16'h3508: t0 = t0 | {16'h0, op[15:0]};
      16'h3409: t1 = {16'h0, op[15:0]};
      16'h8d09: load_t1();
      16'hae69: fast = (s3 == 32'hff20_0000) ? t1 : ~t1;
      16'had09:
      begin
        if (t0 != CTRL_ADDR + `CLR_OFS || t1 != {16'h0, `WRITE_ENABLE_BIT_MASK} || $time - t_zero < `SETTLE_NS || nops < 4)
          viol++;
        ctrl = ctrl & ~t1;
      end
      16'h0000: nops++;
      default: viol++;
    endcase
  endtask : exec
  always @(posedge tck)
  begin
    ones = tms ? ones + 1 : 0;
    if (!master_clear_pin_n)
      pulses++;
    if (st == 3'h4)
      sr = {tdi, sr[31:1]};
    if (st == 3'h3 && !is_ir)
    begin
      sr = (ir == IR_FAST && pe == 3) ? pe_addr + pe_len : fast;
      if (ir == IR_FAST && zero_pend)
      begin
        t_zero = $time;
        nops = 0;
        zero_pend = 1'b0;
      end
    end
    if (st == 3'h6 && is_ir)
      ir = sr[31:27];
    if (st == 3'h6 && !is_ir && ir == IR_INSTR)
      exec(sr);
    if (st == 3'h6 && !is_ir && ir == IR_FAST)
    begin
      pe_addr = (pe == 1) ? sr : pe_addr;
      pe_len = (pe == 2) ? sr : pe_len;
      pe = (sr == CHECKSUM_CMD) ? 1 : (pe == 0 || pe == 3) ? 0 : pe + 1;
    end
    is_ir = (st == 3'h2) ? 1'b1 : (st == 3'h1) ? 1'b0 : is_ir;
    st = !master_clear_pin_n ? 3'h0 : next_st(st, tms);
  end
  // released data line toggles so a stale value is never read as good
  always @(negedge tck)
    tdo <= (st == 3'h4) ? sr[0] : ~tdo;
  always @(tck or tms or tdi)
    if (master_clear_pin_n)
      t_act = $time;
  always @(posedge master_clear_pin_n)
    was_up = 1'b1;
  always @(negedge master_clear_pin_n)
  begin
    if (was_up && (ones < 5 || $time - t_act < `EXIT_HOLD_NS))
      viol++;
    pulses = 0;
    locked = locked | protect;
  end
endmodule : target_device
`default_nettype wire

/* verif/test_flash_verify_exit_host.sv */
`default_nettype none
module test_flash_verify_exit_host import flash_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic exp_valid = 1'b0;
  logic two_wire = 1'b0;
  logic err_inject = 1'b0;
  logic protect = 1'b0;
  logic [31:0] exp_data = 32'h0;
  cmd_t cmd = '0;
  res_t res, got;
  logic cmd_ready, res_valid, exp_ready, tck, tms, tdi, tdo, master_clear_pin_n, target_power;
  int bad_count = 0;
  int n_tests = 0;
  initial
  begin
    forever #20 clk = ~clk;
  end
  flash_verify_exit_host dut (.clk(clk), .reset(reset), .ce(1'b1), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .res_valid(res_valid), .res(res), .exp_valid(exp_valid), .exp_data(exp_data),
    .exp_ready(exp_ready), .two_wire(two_wire), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .master_clear_pin_n(master_clear_pin_n), .target_power(target_power));
  target_device dev (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .master_clear_pin_n(master_clear_pin_n),
    .err_inject(err_inject), .protect(protect));
  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_tests++;
    if (seen !== want)
    begin
      bad_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  function automatic logic [31:0] word_at(input int idx);
    return 32'hc0de_0000 + idx;
  endfunction : word_at
  task automatic run(input op_t op, input logic [31:0] a, input logic [15:0] n, input logic [31:0] ca,
      input logic [15:0] cn, input logic [31:0] sum);
    int k;
    k = 0;
    cmd = '{op, a, n, ca, cn, sum};
    cmd_valid = 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1 && ++k < 100);
    #1;
    cmd_valid = 1'b0;
    if (op != op_power_on)
      check({31'h0, cmd_ready}, 32'h0, "busy refuses");
    k = 0;
    do @(posedge clk); while (res_valid !== 1'b1 && ++k < 60000);
    check({31'h0, res_valid}, 32'h1, "result arrives");
    got = res;
    #1;
  endtask : run
  task automatic push(input logic [31:0] w);
    int k;
    k = 0;
    exp_data = w;
    exp_valid = 1'b1;
    do @(posedge clk); while (exp_ready !== 1'b1 && ++k < 1000);
    #1;
  endtask : push
  // ----
  // scenarios
  // ----
  task automatic sc_power;
    check({30'h0, master_clear_pin_n, target_power}, 32'h0, "pins in reset");
    run(op_power_on, 0, 0, 0, 0, 0);
    check({29'h0, got.ok, master_clear_pin_n, target_power}, 32'h7, "powered up");
  endtask : sc_power
  task automatic sc_finish(input logic err);
    err_inject = err;
    run(op_finish, 0, 0, 0, 0, 0);
    check({31'h0, got.ok}, {31'h0, ~err}, "write error flag");
    check(got.got, err ? 32'h0000_2000 : 32'h0, "control after clear");
    check(dev.viol, 0, "settle before clear store");
  endtask : sc_finish
  task automatic sc_pe(input logic [31:0] sum, input logic good);
    run(op_verify_pe, 32'h0000_0040, 16'h0010, 0, 0, sum);
    check(got.got, 32'h0000_0050, "returned checksum");
    check({31'h0, got.ok}, {31'h0, good}, "checksum compare");
  endtask : sc_pe
  task automatic sc_direct_full;
    for (int i = 0; i < 16; i++)
      push(word_at(i < 14 ? i : 34 + i));
    check({31'h0, exp_ready}, 32'h0, "fifo full");
    exp_data = 32'hdead_0001;
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, exp_ready}, 32'h0, "overfill refused");
    exp_valid = 1'b0;
    run(op_verify_direct, 32'h0, 16'h000e, 32'h0000_00c0, 16'h0002, 0);
    check({31'h0, got.ok}, 32'h1, "code and config verified");
    check({31'h0, exp_ready}, 32'h1, "fifo drained");
  endtask : sc_direct_full
  task automatic sc_direct_fail;
    push(word_at(2));
    push(word_at(3));
    push(word_at(50) ^ 32'h0000_0100);
    exp_valid = 1'b0;
    run(op_verify_direct, 32'h8, 16'h0002, 32'h0000_00c8, 16'h0001, 0);
    check({31'h0, got.ok}, 32'h0, "config mismatch found");
    check(got.fail_addr, 32'h0000_00c8, "failing address");
    check(got.got, word_at(50), "word read back");
  endtask : sc_direct_fail
  task automatic sc_exit(input logic tw);
    two_wire = tw;
    run(op_exit, 0, 0, 0, 0, 0);
    check({29'h0, got.ok, master_clear_pin_n, target_power}, 32'h4, "exit pins");
    check(dev.pulses, {31'h0, tw}, "clock pulses after clear");
    check(dev.viol, 0, "mode ones and hold time");
  endtask : sc_exit
  task automatic sc_locked;
    protect = 1'b1;
    sc_exit(1'b1);
    sc_power();
    push(word_at(0));
    exp_valid = 1'b0;
    run(op_verify_direct, 32'h0, 16'h0001, 32'h0, 16'h0000, 32'h0);
    check({31'h0, got.ok}, 32'h0, "locked device refuses read");
    check(got.got, 32'h0, "locked word reads zero");
  endtask : sc_locked
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    sc_power();
    sc_finish(1'b0);
    sc_finish(1'b1);
    sc_pe(32'h0000_0050, 1'b1);
    sc_pe(32'h0000_0051, 1'b0);
    sc_direct_full();
    sc_direct_fail();
    sc_exit(1'b0);
    sc_power();
    sc_locked();
    end_sim();
  end
  initial
  begin
    #4_000_000;
    bad_count++;
    end_sim();
  end
endmodule : test_flash_verify_exit_host
`default_nettype wire
